/* quad_dac_map.svh */
// Offsets, field positions, reset codes and counts for the quad converter control
`ifndef QUAD_DAC_MAP_SVH
`define QUAD_DAC_MAP_SVH

`define QD_NUM_CH       4
`define QD_CODE_W       16
`define QD_CODE_ZERO    16'h0000
`define QD_CODE_MID     16'h8000
`define QD_INIT_WAIT    2'h3

`define QD_REG_CTRL     5'h00
`define QD_REG_STATUS   5'h04
`define QD_REG_ID       5'h08
`define QD_REG_CODE0    5'h10
`define QD_REG_CODE1    5'h14
`define QD_REG_CODE2    5'h18
`define QD_REG_CODE3    5'h1C

`define QD_CTRL_REF_EN  0
`define QD_ST_CLRMODE   0
`define QD_ST_HS        1
`define QD_ST_BUSY      2
`define QD_ST_INIT      3
`define QD_ST_PEND_LO   4

`define QD_HS_CODE      5'h01
`define QD_CMD_UPD_BIT  4
`define QD_LAST_BYTE    2'h3
`define QD_BITS_BYTE    4'h8
`define QD_BIT_LAST     4'h7

`endif

/* quad_dac_pkg.sv */
// Types shared by the quad converter control block
package quad_dac_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RECV = 3'h1,
		ST_ACK  = 3'h3,
		ST_SEND = 3'h2,
		ST_MACK = 3'h6
	} serial_state_e;

	typedef enum logic [1:0] {
		LVL_LOW   = 2'h0,
		LVL_HIGH  = 2'h1,
		LVL_FLOAT = 2'h3
	} pin_level_e;

endpackage

/* tristate_level_sense.sv */
// Three-level decoder for one address-select pin
`timescale 1ns/1ns
module tristate_level_sense
	import quad_dac_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset,
	// Pad seen with weak pull-up and with weak pull-down
	input  wire logic pin_pu,
	input  wire logic pin_pd,
	// Decoded level
	output pin_level_e level
);

	logic [1:0] sync1_reg;
	logic [1:0] sync2_reg;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sync1_reg <= 2'h0;
			sync2_reg <= 2'h0;
		end else begin
			sync1_reg <= {pin_pu, pin_pd};
			sync2_reg <= sync1_reg;
		end
	end

	// A floating pin follows whichever pull is applied; a driven one ignores both
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			level <= LVL_LOW;
		end else begin
			unique case (sync2_reg)
				2'h3:    level <= LVL_HIGH;
				2'h0:    level <= LVL_LOW;
				default: level <= LVL_FLOAT;
			endcase
		end
	end

endmodule

/* quad_dac_update_clear_control.sv */
// Quad converter control: serial load, two-stage code registers, load strobe, clear
`timescale 1ns/1ns
`include "quad_dac_map.svh"
// Summary of operation
// - Load strobe low moves every pending input register into its converter register.
// - Low address pin sets slave address bits one and zero.
// - High address pin sets slave address bits three and two.
// - Power-up level pin selects zero or midscale for all outputs.
// - Clear input zeroes only on its falling edge, independent of serial clock.
// - While clear input is low, load strobe causes no transfer.
// - Clear loads zero into every input and converter register.
// - Clear-code mode ends at ninth clock falling edge of last byte.
// - Clear during a serial write aborts it and discards partial data.
// - Clear drops the interface out of high speed mode.
// - Data line is open drain; device only pulls low or releases.
// - Each channel has a 16-bit input register written or read serially.
// - Code zero is zero scale on the converter output.
// - Code all-ones is full scale, one step below the top.
// - Reference pin defaults to input use after power-up.
// - On-chip reference stays off until software enables it.
// - Converter codes are straight binary.
module quad_dac_update_clear_control
	import quad_dac_pkg::*;
#(
	parameter bit         HAS_HIGH_PIN = 1'b1,
	parameter logic [2:0] ADDR_UPPER   = 3'h1, // Arbitrary value
	parameter logic [1:0] ADDR_MID_DEF = 2'h0
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// Serial bus
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// Hardware strobes and straps
	input  wire logic        load_strobe_n,
	input  wire logic        async_zero_n,
	input  wire logic        por_level_pin,
	input  wire logic        slave_id_low_pin_pu,
	input  wire logic        slave_id_low_pin_pd,
	input  wire logic        slave_id_high_pin_pu,
	input  wire logic        slave_id_high_pin_pd,
	// Register port
	input  wire logic [4:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Converter side
	output logic      [15:0] dac_a_code,
	output logic      [15:0] dac_b_code,
	output logic      [15:0] dac_c_code,
	output logic      [15:0] dac_d_code,
	output logic             reference_drive_en
);

	localparam int N = `QD_NUM_CH;
	localparam int W = `QD_CODE_W;

	logic [4:0]    sync1_reg;
	logic [4:0]    sync2_reg;
	logic [4:0]    prev_reg;
	logic          scl_s, sda_s, ld_s, clr_s, por_s, scl_p, sda_p, clr_p;
	logic          scl_rise, scl_fall, start_det, stop_det, clr_fall;
	logic [1:0]    init_cnt_reg;
	logic          init_done_reg, init_load;
	pin_level_e    low_level, high_level;
	logic [6:0]    slave_addr_reg;
	serial_state_e state_reg;
	logic [3:0]    bit_cnt_reg;
	logic [1:0]    byte_idx_reg;
	logic [7:0]    shift_reg, cmd_reg, hi_reg;
	logic [15:0]   tx_reg;
	logic          rw_reg, hs_reg, clear_mode_reg, ref_en_reg;
	logic          byte_end, byte_ok, hs_seen, wr_done, wr_upd, load_go;
	logic [1:0]    wr_ch;
	logic [W-1:0]  wr_data, por_code;
	logic [W-1:0]  input_reg [N];
	logic [W-1:0]  dac_reg [N];
	logic [N-1:0]  pending_reg;
	logic [31:0]   rd_word;

	function automatic logic [1:0] id_bits(input pin_level_e l);
		unique case (l)
			LVL_LOW:  id_bits = 2'h0;
			LVL_HIGH: id_bits = 2'h3;
			default:  id_bits = 2'h2;
		endcase
	endfunction

	// Pins and the clear input are asynchronous to clk_sys
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sync1_reg <= 5'h1F;
			sync2_reg <= 5'h1F;
			prev_reg  <= 5'h1F;
		end else begin
			sync1_reg <= {scl_in, sda_in, load_strobe_n, async_zero_n, por_level_pin};
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	assign {scl_s, sda_s, ld_s, clr_s, por_s} = sync2_reg;
	assign scl_p     = prev_reg[4];
	assign sda_p     = prev_reg[3];
	assign clr_p     = prev_reg[1];
	assign scl_rise  = scl_s & ~scl_p;
	assign scl_fall  = ~scl_s & scl_p;
	assign start_det = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;
	assign clr_fall  = clr_p & ~clr_s;

	tristate_level_sense u_low_pin (
		.clk_sys (clk_sys),
		.reset   (reset),
		.pin_pu  (slave_id_low_pin_pu),
		.pin_pd  (slave_id_low_pin_pd),
		.level   (low_level)
	);

	tristate_level_sense u_high_pin (
		.clk_sys (clk_sys),
		.reset   (reset),
		.pin_pu  (slave_id_high_pin_pu),
		.pin_pd  (slave_id_high_pin_pd),
		.level   (high_level)
	);

	// Straps are caught once the synchronisers have filled after reset
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			init_cnt_reg   <= 2'h0;
			init_done_reg  <= 1'b0;
			slave_addr_reg <= 7'h00;
		end else if (!init_done_reg) begin
			init_cnt_reg <= init_cnt_reg + 2'h1;
			if (init_load) begin
				init_done_reg  <= 1'b1;
				slave_addr_reg[6:4] <= ADDR_UPPER;
				slave_addr_reg[3:2] <= HAS_HIGH_PIN ? id_bits(high_level) : ADDR_MID_DEF;
				slave_addr_reg[1:0] <= id_bits(low_level);
			end
		end
	end

	assign init_load = ~init_done_reg & (init_cnt_reg == `QD_INIT_WAIT);
	assign por_code  = por_s ? `QD_CODE_MID : `QD_CODE_ZERO;

	// Serial engine: address, command, high byte, low byte
	assign byte_end = (state_reg == ST_RECV) & scl_fall & (bit_cnt_reg == `QD_BITS_BYTE);
	assign hs_seen  = byte_end & (byte_idx_reg == 2'h0) & (shift_reg[7:3] == `QD_HS_CODE);
	assign byte_ok  = (byte_idx_reg == 2'h0) ? (shift_reg[7:1] == slave_addr_reg) : ~rw_reg;
	assign wr_done  = (state_reg == ST_ACK) & scl_fall & (byte_idx_reg == `QD_LAST_BYTE)
	                  & ~rw_reg & ~clr_fall;
	assign wr_ch    = cmd_reg[1:0];
	assign wr_upd   = cmd_reg[`QD_CMD_UPD_BIT];
	assign wr_data  = {hi_reg, shift_reg};

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_reg    <= ST_IDLE;
			bit_cnt_reg  <= 4'h0;
			byte_idx_reg <= 2'h0;
			shift_reg    <= 8'h00;
			cmd_reg      <= 8'h00;
			hi_reg       <= 8'h00;
			tx_reg       <= 16'h0000;
			rw_reg       <= 1'b0;
		end else if (clr_fall || stop_det || !init_done_reg) begin
			state_reg <= ST_IDLE;
		end else if (start_det) begin
			state_reg    <= ST_RECV;
			bit_cnt_reg  <= 4'h0;
			byte_idx_reg <= 2'h0;
		end else begin
			unique case (state_reg)
				default: state_reg <= ST_IDLE;
				ST_RECV: begin
					if (scl_rise && bit_cnt_reg != `QD_BITS_BYTE) begin
						shift_reg   <= {shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (byte_end) begin
						bit_cnt_reg <= 4'h0;
						state_reg   <= (byte_ok && !hs_seen) ? ST_ACK : ST_IDLE;
						if (byte_idx_reg == 2'h0) begin
							rw_reg <= shift_reg[0];
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (byte_idx_reg == 2'h1) begin
							cmd_reg <= shift_reg;
						end
						if (byte_idx_reg == 2'h2) begin
							hi_reg <= shift_reg;
						end
						// Further byte pairs stream into the same channel
						byte_idx_reg <= (byte_idx_reg == `QD_LAST_BYTE) ? 2'h2
						                : byte_idx_reg + 2'h1;
						if (rw_reg) begin
							tx_reg    <= input_reg[wr_ch];
							state_reg <= ST_SEND;
						end else begin
							state_reg <= ST_RECV;
						end
					end
				end
				ST_SEND: begin
					if (scl_fall) begin
						tx_reg      <= {tx_reg[14:0], tx_reg[15]};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (bit_cnt_reg == `QD_BIT_LAST) begin
							bit_cnt_reg <= 4'h0;
							state_reg   <= ST_MACK;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise && sda_s) begin
						state_reg <= ST_IDLE;
					end else if (scl_fall) begin
						state_reg <= ST_SEND;
					end
				end
			endcase
		end
	end

	// Only ever pull low; the pull-up is outside
	assign sda_out = 1'b0;
	assign sda_oe  = (state_reg == ST_ACK) | ((state_reg == ST_SEND) & ~tx_reg[15]);

	// High speed mode lasts until stop or clear
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			hs_reg <= 1'b0;
		end else if (clr_fall || stop_det) begin
			hs_reg <= 1'b0;
		end else if (hs_seen) begin
			hs_reg <= 1'b1;
		end
	end

	// Clear-code mode; a clear edge cannot coincide with a completing write
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			clear_mode_reg <= 1'b0;
		end else if (clr_fall) begin
			clear_mode_reg <= 1'b1;
		end else if (wr_done) begin
			clear_mode_reg <= 1'b0;
		end
	end

	// Level sense covers both a pulsed and a tied-low strobe
	assign load_go = ~ld_s & clr_s & init_done_reg;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pending_reg <= '0;
			for (int c = 0; c < N; c++) begin
				input_reg[c] <= `QD_CODE_ZERO;
				dac_reg[c]   <= `QD_CODE_ZERO;
			end
		end else if (init_load) begin
			pending_reg <= '0;
			for (int c = 0; c < N; c++) begin
				input_reg[c] <= por_code;
				dac_reg[c]   <= por_code;
			end
		end else if (clr_fall) begin
			pending_reg <= '0;
			for (int c = 0; c < N; c++) begin
				input_reg[c] <= `QD_CODE_ZERO;
				dac_reg[c]   <= `QD_CODE_ZERO;
			end
		end else begin
			for (int c = 0; c < N; c++) begin
				// An input-only write landing with a transfer keeps the pending flag set
				if (wr_done && wr_ch == c[1:0]) begin
					input_reg[c] <= wr_data;
				end
				if (wr_done && wr_upd && wr_ch == c[1:0]) begin
					dac_reg[c] <= wr_data;
				end else if (load_go && pending_reg[c]) begin
					dac_reg[c] <= input_reg[c];
				end
				pending_reg[c] <= (pending_reg[c] & ~load_go)
				                  | (wr_done & ~wr_upd & (wr_ch == c[1:0]));
			end
		end
	end

	// Codes pass straight binary to the string; zero and all-ones are the ends
	assign dac_a_code = dac_reg[0];
	assign dac_b_code = dac_reg[1];
	assign dac_c_code = dac_reg[2];
	assign dac_d_code = dac_reg[3];

	// Reference stays an input until software turns the on-chip source on
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ref_en_reg <= 1'b0;
		end else if (reg_wr && reg_addr == `QD_REG_CTRL) begin
			ref_en_reg <= reg_wdata[`QD_CTRL_REF_EN];
		end
	end

	assign reference_drive_en = ref_en_reg;

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (reg_addr)
			`QD_REG_CTRL:   rd_word[`QD_CTRL_REF_EN] = ref_en_reg;
			`QD_REG_STATUS: rd_word[7:0] = {pending_reg, init_done_reg,
			                                state_reg != ST_IDLE, hs_reg, clear_mode_reg};
			`QD_REG_ID:     rd_word[6:0] = slave_addr_reg;
			`QD_REG_CODE0:  rd_word[15:0] = dac_reg[0];
			`QD_REG_CODE1:  rd_word[15:0] = dac_reg[1];
			`QD_REG_CODE2:  rd_word[15:0] = dac_reg[2];
			`QD_REG_CODE3:  rd_word[15:0] = dac_reg[3];
			default:        rd_word = 32'h0000_0000;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_rd ? rd_word : 32'h0000_0000;
		end
	end

	a_load_moves: assert property (@(posedge clk_sys) disable iff (reset)
		(load_go && pending_reg[0] && !clr_fall && !wr_done && !init_load)
		|=> (dac_reg[0] == $past(input_reg[0])) && !pending_reg[0])
		else $error("pending code not moved on load strobe");

	a_tied_low: assert property (@(posedge clk_sys) disable iff (reset)
		(load_go && !wr_done) |=> (pending_reg == 4'h0))
		else $error("pending flag survived a low load strobe");

	a_low_pin_bits: assert property (@(posedge clk_sys) disable iff (reset)
		init_load |=> (slave_addr_reg[1:0] == id_bits($past(low_level))))
		else $error("low address bits not taken from pin");

	a_por_level: assert property (@(posedge clk_sys) disable iff (reset)
		init_load |=> (dac_reg[2] == ($past(por_s) ? `QD_CODE_MID : `QD_CODE_ZERO)))
		else $error("power-up level wrong");

	a_clear_holds: assert property (@(posedge clk_sys) disable iff (reset)
		(init_done_reg && !clr_s && !clr_fall && !wr_done) |=> $stable(dac_reg[0]))
		else $error("converter code moved while clear held low");

	a_clear_zero: assert property (@(posedge clk_sys) disable iff (reset)
		(clr_fall && init_done_reg) |=> (dac_reg[3] == `QD_CODE_ZERO)
		&& (input_reg[0] == `QD_CODE_ZERO) && clear_mode_reg)
		else $error("clear did not load zero scale");

	a_clear_exit: assert property (@(posedge clk_sys) disable iff (reset)
		(clear_mode_reg && wr_done) |=> !clear_mode_reg)
		else $error("clear-code mode not left after write");

	a_write_abort: assert property (@(posedge clk_sys) disable iff (reset)
		(clr_fall && state_reg != ST_IDLE) |=> (state_reg == ST_IDLE) ##1 !sda_oe)
		else $error("write not aborted by clear");

	a_hs_drop: assert property (@(posedge clk_sys) disable iff (reset)
		clr_fall |=> !hs_reg)
		else $error("high speed mode kept after clear");

	a_sda_drive: assert property (@(posedge clk_sys) disable iff (reset)
		sda_oe |-> !sda_out && ((state_reg == ST_SEND) || (byte_idx_reg != 2'h0)
		|| (shift_reg[7:1] == slave_addr_reg)))
		else $error("data line pulled outside acknowledge or send");

	a_ref_default: assert property (@(posedge clk_sys) disable iff (reset)
		(!reference_drive_en && !(reg_wr && reg_addr == `QD_REG_CTRL)) |=> !reference_drive_en)
		else $error("reference enabled without a write");

endmodule

/* i2c_master_model.sv */
// Two-wire bus master model: drives the serial clock and pulls the data line
`timescale 1ns/1ns
module i2c_master_model (
	// Clock
	input  wire logic clk_sys,
	// Bus lines
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_pull
);
	// Quarter bit time in system clocks; slow enough for the device's pin sync
	int q = 5;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// Lines change only after a clock edge; data is only pulled low or released
	task automatic step(input logic c, input logic p);
		@(posedge clk_sys);
		scl <= c;
		sda_pull <= p;
		repeat (q - 1) @(posedge clk_sys);
	endtask
	task automatic begin_frame();
		step(1'b1, 1'b1);
		step(1'b0, 1'b1);
	endtask
	task automatic end_frame();
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
	endtask
	task automatic bit_io(input logic b, output logic r);
		step(1'b0, ~b);
		step(1'b1, ~b);
		r = sda_line;
		step(1'b1, ~b);
		step(1'b0, ~b);
	endtask
	// Clock stands still between frames; a released line reads high through the pull-up
	task automatic byte_io(input logic [7:0] tx, input logic ninth, output logic [7:0] rx,
			output logic ninth_rx);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ninth, ninth_rx);
	endtask
endmodule

/* quad_dac_update_clear_control_test.sv */
// Self-checking bench for the quad converter update and clear control
`timescale 1ns/1ns
`include "quad_dac_map.svh"
`define CHECK_EQ(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin errors++; \
	$display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module quad_dac_update_clear_control_test;
	import quad_dac_pkg::*;
	typedef struct {logic [1:0] ch; logic upd; logic [15:0] data;} row_s;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic        load_strobe_n = 1'b1;
	logic        async_zero_n = 1'b1;
	logic        por_pin = 1'b0;
	logic [3:0]  straps = 4'h3;
	logic [4:0]  reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic [31:0] rd;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        scl, sda_pull, sda_out, sda_oe, ref_en, ack;
	logic [7:0]  rx, hi;
	logic [15:0] dac [4];
	logic [15:0] exp_dac [4];
	logic [15:0] exp_in [4];
	logic [6:0]  dev_addr = 7'h13;
	int          errors = 0;
	int          num_checks = 0;
	// Full scale, zero scale, input-only and direct updates across all channels
	row_s rows [6] = '{'{2'h0, 1'b1, 16'hFFFF}, '{2'h1, 1'b1, 16'h0000},
		'{2'h2, 1'b0, 16'h1234}, '{2'h3, 1'b0, 16'hABCD}, '{2'h0, 1'b0, 16'h5A5A},
		'{2'h1, 1'b1, 16'h8001}};
	// Open-drain data line with pull-up
	wire sda_line = ~(sda_pull | (sda_oe & ~sda_out));

	always #50 clk_sys = ~clk_sys;

	quad_dac_update_clear_control i_quad_dac_update_clear_control (
		.clk_sys(clk_sys), .reset(reset), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .load_strobe_n(load_strobe_n),
		.async_zero_n(async_zero_n), .por_level_pin(por_pin),
		.slave_id_low_pin_pu(straps[0]), .slave_id_low_pin_pd(straps[1]),
		.slave_id_high_pin_pu(straps[2]), .slave_id_high_pin_pd(straps[3]),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .dac_a_code(dac[0]), .dac_b_code(dac[1]),
		.dac_c_code(dac[2]), .dac_d_code(dac[3]), .reference_drive_en(ref_en));
	i2c_master_model i_i2c_master_model (
		.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [4:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask
	task automatic wr(input logic [7:0] b, input logic nak);
		i_i2c_master_model.byte_io(b, 1'b1, rx, ack);
		`CHECK_EQ("ack", nak, ack);
	endtask
	task automatic dac_write(input logic [1:0] ch, input logic upd, input logic [15:0] d);
		i_i2c_master_model.begin_frame();
		wr({dev_addr, 1'b0}, 1'b0);
		wr({3'h0, upd, 2'h0, ch}, 1'b0);
		wr(d[15:8], 1'b0);
		wr(d[7:0], 1'b0);
		i_i2c_master_model.end_frame();
		tick(8);
		exp_in[ch] = d;
	endtask
	task automatic check_dacs();
		for (int i = 0; i < 4; i++) begin
			`CHECK_EQ("dac code", exp_dac[i], dac[i]);
		end
	endtask
	task automatic do_reset(input logic por, input logic [3:0] s);
		@(posedge clk_sys);
		reset <= 1'b1;
		por_pin <= por;
		straps <= s;
		tick(16);
		reset <= 1'b0;
		tick(10);
		exp_dac = '{4{por ? `QD_CODE_MID : `QD_CODE_ZERO}};
	endtask
	task automatic strobe_pulse();
		@(posedge clk_sys);
		load_strobe_n <= 1'b0;
		@(posedge clk_sys);
		load_strobe_n <= 1'b1;
		tick(6);
	endtask
	task automatic clear_fall();
		@(posedge clk_sys);
		async_zero_n <= 1'b0;
		tick(6);
	endtask

	// Watchdog sized well above the expected run of about 9600 cycles
	initial begin
		tick(40000);
		errors++;
		results();
	end

	initial begin
		do_reset(1'b0, 4'h3);
		check_dacs();
		`CHECK_EQ("ref enable", 1'b0, ref_en);
		reg_read(`QD_REG_ID);
		`CHECK_EQ("slave id", 32'h13, rd);
		reg_read(5'h0C);
		`CHECK_EQ("unmapped", 32'h0, rd);
		foreach (rows[r]) begin
			dac_write(rows[r].ch, rows[r].upd, rows[r].data);
			if (rows[r].upd) exp_dac[rows[r].ch] = rows[r].data;
			check_dacs();
		end
		reg_read(`QD_REG_STATUS);
		`CHECK_EQ("pending", 4'hD, rd[7:4]);
		strobe_pulse();
		exp_dac = exp_in;
		check_dacs();
		// Serial read returns the input register of the last commanded channel
		i_i2c_master_model.begin_frame();
		wr({dev_addr, 1'b0}, 1'b0);
		wr(8'h02, 1'b0);
		i_i2c_master_model.end_frame();
		i_i2c_master_model.begin_frame();
		wr({dev_addr, 1'b1}, 1'b0);
		i_i2c_master_model.byte_io(8'hFF, 1'b0, hi, ack);
		i_i2c_master_model.byte_io(8'hFF, 1'b1, rx, ack);
		i_i2c_master_model.end_frame();
		`CHECK_EQ("read back", 16'h1234, {hi, rx});
		reg_write(`QD_REG_CTRL, 32'h1);
		tick(2);
		`CHECK_EQ("ref enable", 1'b1, ref_en);
		// Clear zeroes everything; being edge sensed, writes still land while held low
		clear_fall();
		exp_dac = '{4{16'h0000}};
		check_dacs();
		reg_read(`QD_REG_STATUS);
		`CHECK_EQ("clear mode", 1'b1, rd[`QD_ST_CLRMODE]);
		dac_write(2'h1, 1'b1, 16'h4321);
		exp_dac[1] = 16'h4321;
		check_dacs();
		reg_read(`QD_REG_STATUS);
		`CHECK_EQ("clear mode", 1'b0, rd[`QD_ST_CLRMODE]);
		dac_write(2'h0, 1'b0, 16'h7777);
		strobe_pulse();
		check_dacs();
		@(posedge clk_sys);
		async_zero_n <= 1'b1;
		strobe_pulse();
		exp_dac[0] = 16'h7777;
		check_dacs();
		// Clear in mid-write discards the partial word
		i_i2c_master_model.begin_frame();
		wr({dev_addr, 1'b0}, 1'b0);
		wr(8'h12, 1'b0);
		wr(8'h99, 1'b0);
		clear_fall();
		wr(8'h66, 1'b1);
		i_i2c_master_model.end_frame();
		tick(8);
		exp_dac = '{4{16'h0000}};
		check_dacs();
		reg_read(`QD_REG_STATUS);
		`CHECK_EQ("busy", 1'b0, rd[`QD_ST_BUSY]);
		@(posedge clk_sys);
		async_zero_n <= 1'b1;
		// High speed master code, then a clear drops the mode
		i_i2c_master_model.begin_frame();
		wr(8'h08, 1'b1);
		reg_read(`QD_REG_STATUS);
		`CHECK_EQ("high speed", 1'b1, rd[`QD_ST_HS]);
		clear_fall();
		reg_read(`QD_REG_STATUS);
		`CHECK_EQ("high speed", 1'b0, rd[`QD_ST_HS]);
		i_i2c_master_model.end_frame();
		@(posedge clk_sys);
		async_zero_n <= 1'b1;
		// Strobe tied low: each finished write reaches the output at once
		@(posedge clk_sys);
		load_strobe_n <= 1'b0;
		dac_write(2'h3, 1'b0, 16'h2468);
		exp_dac[3] = 16'h2468;
		check_dacs();
		load_strobe_n <= 1'b1;
		// Midscale start, floating low pin, high pin tied high
		do_reset(1'b1, 4'hD);
		dev_addr = 7'h1E;
		check_dacs();
		`CHECK_EQ("ref enable", 1'b0, ref_en);
		reg_read(`QD_REG_ID);
		`CHECK_EQ("slave id", 32'h1E, rd);
		dac_write(2'h2, 1'b1, 16'h0F0F);
		exp_dac[2] = 16'h0F0F;
		check_dacs();
		results();
	end
endmodule
